// File: sdd_display_driver.sv
// Four-digit seven-segment display decoder and LCD driver
// Summary of operation
// - Data nibble is true binary, bit three MSB
// - Digit select stores decoded data into digit
// - Address 00 most significant, 11 least digit
// - Both chip selects low load holding latches
// - Either chip select rising writes addressed digit
// - Twenty-eight segment outputs plus one backplane
// - Backplane is oscillator divided by 128
// - Oscillator near 19 kHz, backplane near 150 Hz
// - Pin held low disables backplane, follows input
// - Low pulses under one microsecond are ignored
// - Decode hexadecimal or code B patterns
`timescale 1ns/1ns
`include "sdd_defines.svh"

module sdd_display_driver
  import sdd_pkg::*;
#(
  parameter int OSC_CYCLES = `SDD_OSC_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_proc_mode,
  input wire logic i_code_b,
  input wire logic i_nibble_bit_ones,
  input wire logic i_nibble_bit_twos,
  input wire logic i_nibble_bit_fours,
  input wire logic i_nibble_bit_eights,
  input wire logic i_digit_one_select,
  input wire logic i_digit_two_select,
  input wire logic i_digit_three_select,
  input wire logic i_digit_four_select,
  input wire logic i_chip_sel_first_n,
  input wire logic i_chip_sel_second_n,
  input wire logic i_timebase_pin,
  input wire logic i_common_plane,
  output logic o_common_plane,
  output logic o_common_plane_oe,
  output logic [27:0] o_segments
);

  // ============================================================
  // Decoding
  // ============================================================
  // Map a nibble onto segments g..a, hex or code B set
  function automatic sdd_seg_t seg_decode(input logic [3:0] n, input logic code_b);
    sdd_seg_t s;
    s = 7'h00;
    case (n)
      4'h0: s = 7'h3f;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5b;
      4'h3: s = 7'h4f;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6d;
      4'h6: s = 7'h7d;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7f;
      4'h9: s = 7'h6f;
      4'ha: s = code_b ? 7'h40 : 7'h77;
      4'hb: s = code_b ? 7'h79 : 7'h7c;
      4'hc: s = code_b ? 7'h76 : 7'h39;
      4'hd: s = code_b ? 7'h38 : 7'h5e;
      4'he: s = code_b ? 7'h73 : 7'h79;
      default: s = code_b ? 7'h00 : 7'h71;
    endcase
    return s;
  endfunction

  // Digit index from the processor address, 00 names the top digit
  function automatic logic [1:0] addr_to_index(input logic [1:0] a);
    return ~a;
  endfunction

  // ============================================================
  // Input gathering
  // ============================================================
  logic [3:0] nibble;       // Present data nibble
  logic [3:0] digit_sel;    // Multiplexed selects, one lowest
  logic cs_both_low;        // Both chip selects active

  assign nibble = {i_nibble_bit_eights, i_nibble_bit_fours,
                   i_nibble_bit_twos, i_nibble_bit_ones};
  assign digit_sel = {i_digit_four_select, i_digit_three_select,
                      i_digit_two_select, i_digit_one_select};
  assign cs_both_low = !i_chip_sel_first_n && !i_chip_sel_second_n;

  // ============================================================
  // Processor port capture
  // ============================================================
  sdd_cap_state_t cap_state;  // Capture state
  sdd_hold_t hold;            // Holding latches
  logic proc_fire;            // Write strobe for the held value

  assign proc_fire = i_proc_mode && (cap_state == SDD_HOLD) && !cs_both_low;

  // Capture state tracks the chip select pair
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cap_state <= SDD_IDLE;
    end else begin
      case (cap_state)
        SDD_IDLE: begin
          // Both selects low opens the latches
          if (i_proc_mode && cs_both_low) begin
            cap_state <= SDD_HOLD;
          end
        end
        SDD_HOLD: begin
          // Either select rising closes them
          if (!cs_both_low || !i_proc_mode) begin
            cap_state <= SDD_IDLE;
          end
        end
        default: cap_state <= SDD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold <= '0;
    end else if (i_proc_mode && cs_both_low) begin
      hold <= '{addr: {i_chip_sel_first_n ? 1'b0 : i_digit_two_select,
                       i_digit_one_select}, nibble: nibble};
    end
  end

  // ============================================================
  // Digit output latches
  // ============================================================
  sdd_seg_t digit_q [4];      // Stored pattern per digit
  logic [3:0] digit_wr;       // Write strobe per digit
  sdd_seg_t proc_pat;         // Decoded held nibble
  sdd_seg_t mux_pat;          // Decoded present nibble

  assign proc_pat = seg_decode(hold.nibble, i_code_b);
  assign mux_pat = seg_decode(nibble, i_code_b);

  // Write strobes for either input configuration
  always_comb begin
    digit_wr = 4'h0;
    if (i_proc_mode) begin
      if (proc_fire) begin
        digit_wr[addr_to_index(hold.addr)] = 1'b1;
      end
    end else begin
      digit_wr = digit_sel;
    end
  end

  // Latch each digit on its strobe
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < `SDD_DIGITS; i++) begin
        digit_q[i] <= `SDD_DIGIT_RST;
      end
    end else begin
      for (int i = 0; i < `SDD_DIGITS; i++) begin
        if (digit_wr[i]) begin
          digit_q[i] <= i_proc_mode ? proc_pat : mux_pat;
        end
      end
    end
  end

  // ============================================================
  // Oscillator and backplane divider
  // ============================================================
  logic [12:0] osc_cnt;                // Master clocks within a tick
  logic osc_tick;                      // One oscillator period done
  logic [`SDD_BP_DIV_W-1:0] bp_div;    // Divide by 128 chain
  logic bp_int;                        // Internal backplane phase

  assign osc_tick = (osc_cnt == 13'(OSC_CYCLES - 1));
  assign bp_int = bp_div[`SDD_BP_BIT];

  // Oscillator period counter
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      osc_cnt <= 13'h0000;
    end else if (osc_tick) begin
      osc_cnt <= 13'h0000;
    end else begin
      osc_cnt <= osc_cnt + 13'h0001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bp_div <= 7'h00;
    end else if (osc_tick) begin
      bp_div <= bp_div + 7'h01;
    end
  end

  // ============================================================
  // Backplane disable detector
  // ============================================================
  logic [6:0] low_cnt;   // Consecutive low cycles on the pin
  logic slave;           // Backplane driver disabled

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt <= 7'h00;
    end else if (i_timebase_pin) begin
      low_cnt <= 7'h00;
    end else if (low_cnt != 7'(`SDD_DIS_CYCLES)) begin
      low_cnt <= low_cnt + 7'h01;
    end
  end

  assign slave = (low_cnt == 7'(`SDD_DIS_CYCLES));

  // ============================================================
  // Output drivers
  // ============================================================
  logic phase;           // Phase the segments follow
  logic [27:0] lit;      // All lit segments, digit one lowest

  assign phase = slave ? i_common_plane : bp_int;
  assign lit = {digit_q[3], digit_q[2], digit_q[1], digit_q[0]};

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_common_plane <= 1'b0;
      o_common_plane_oe <= 1'b0;
    end else begin
      o_common_plane <= bp_int;
      o_common_plane_oe <= !slave;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_segments <= `SDD_SEG_RST;
    end else begin
      o_segments <= lit ^ {28{phase}};
    end
  end

  // ============================================================
  // Checks
  // ============================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  chk_bp_rise: assert property (
    osc_tick && bp_div == 7'h3f |=> o_common_plane == 1'b0 ##1 o_common_plane)
    else $error("backplane did not rise after 64 ticks");
  chk_bp_fall: assert property (
    osc_tick && bp_div == 7'h7f |=> ##1 !o_common_plane)
    else $error("backplane did not fall after 128 ticks");
  chk_slave_oe: assert property (
    (!i_timebase_pin)[*8] ##1 slave |=> !o_common_plane_oe)
    else $error("backplane driver stayed on while pin low");
  chk_short_low: assert property (
    i_timebase_pin ##1 (!i_timebase_pin)[*8] |-> !slave)
    else $error("short low pulse disabled backplane");
  chk_seg_phase: assert property (
    $stable(phase) && digit_wr == 4'h0 |=> o_segments == (lit ^ {28{$past(phase)}}))
    else $error("segment phase wrong");
  chk_addr_top: assert property (
    proc_fire && hold.addr == 2'b00 |=> digit_q[3] == $past(proc_pat))
    else $error("address 00 missed top digit");
  chk_addr_low: assert property (
    proc_fire && hold.addr == 2'b11 |=> digit_q[0] == $past(proc_pat))
    else $error("address 11 missed low digit");
  chk_mux_store: assert property (
    !i_proc_mode && i_digit_one_select |=> digit_q[0] == $past(mux_pat))
    else $error("digit select did not store");
  chk_hold_keep: assert property (
    !digit_wr[1] |=> $stable(digit_q[1]))
    else $error("digit changed without write");
  chk_cs_load: assert property (
    i_proc_mode && cs_both_low |=> hold.nibble == $past(nibble))
    else $error("holding latch did not load");
  chk_cs_fire: assert property (
    i_proc_mode && cs_both_low ##1 !cs_both_low && i_proc_mode |-> proc_fire)
    else $error("chip select release did not write");

  cov_proc_write: cover property (proc_fire ##1 !slave);
  cov_mux_write: cover property (!i_proc_mode && digit_sel == 4'h8);
  cov_slave: cover property (!slave ##1 slave);
  cov_code_b: cover property (proc_fire && i_code_b && hold.nibble == 4'hf);

endmodule

// File: sdd_defines.svh
// Constants for the four-digit segment display driver
`ifndef SDD_DEFINES_SVH
`define SDD_DEFINES_SVH

// ============================================================
// Clock and timing
// ============================================================
// Master clock rate in hertz
`define SDD_MCLK_HZ 100000000
// Free-running oscillator rate in hertz
`define SDD_OSC_HZ 19000
// Master clocks per oscillator tick, rounded down
`define SDD_OSC_CYCLES (`SDD_MCLK_HZ / `SDD_OSC_HZ)
// Shortest low time that disables the backplane, in ns
`define SDD_DIS_FILTER_NS 1000
// Disable filter length in master clocks, rounded up
`define SDD_DIS_CYCLES ((`SDD_DIS_FILTER_NS * (`SDD_MCLK_HZ / 1000000) + 999) / 1000)

// ============================================================
// Divider and fields
// ============================================================
// Oscillator ticks per backplane period
`define SDD_BP_DIVIDE 128
// Width of the backplane divider
`define SDD_BP_DIV_W 7
// Bit of the divider that forms the backplane
`define SDD_BP_BIT 6
// Segments per digit
`define SDD_SEG_W 7
// Number of digits
`define SDD_DIGITS 4

// ============================================================
// Reset values
// ============================================================
// Digit latches reset dark
`define SDD_DIGIT_RST 7'h00
// Segment pins reset low
`define SDD_SEG_RST 28'h0000000

`endif

// File: sdd_pkg.sv
// Types shared by the segment display driver
package sdd_pkg;
  // One digit's segment pattern, bit 0 is segment a, bit 6 is g
  typedef logic [6:0] sdd_seg_t;
  // Input holding latch for the processor port
  typedef struct packed {
    logic [1:0] addr;   // Digit address, high bit first
    logic [3:0] nibble; // Held data nibble
  } sdd_hold_t;
  // Processor port capture state
  typedef enum logic [0:0] {
    SDD_IDLE = 1'b0,    // Chip selects not both low
    SDD_HOLD = 1'b1     // Holding latches loading
  } sdd_cap_state_t;
endpackage

// File: sdd_unused_none.sv
// Holds no logic; the driver file carries the driver module
`timescale 1ns/1ns

// File: sdd_source_model.sv
// Far-side model: multiplexed BCD source or processor bus
`timescale 1ns/1ns
module sdd_source_model (
  input wire logic i_mclk,
  output logic [3:0] o_nibble,
  output logic [3:0] o_select,
  output logic o_cs_first_n,
  output logic o_cs_second_n
);
  // ============================================================
  // Idle levels
  // ============================================================
  initial begin
    o_nibble = 4'h0;
    o_select = 4'h0;
    o_cs_first_n = 1'b1;
    o_cs_second_n = 1'b1;
  end

  // true binary nibble, one select for one edge
  task automatic mux_write(input logic [1:0] digit, input logic [3:0] val);
    @(negedge i_mclk);
    o_nibble <= val;
    o_select <= 4'h1 << digit;
    @(negedge i_mclk);
    o_select <= 4'h0;
    // Released data shows the inverse
    o_nibble <= ~val;
  endtask

  // both selects low one edge, then either one rises first
  task automatic proc_write(input logic [1:0] addr, input logic [3:0] val,
                            input logic second_first);
    @(negedge i_mclk);
    o_select <= {2'h0, addr};
    o_nibble <= val;
    o_cs_first_n <= 1'b0;
    o_cs_second_n <= 1'b0;
    @(negedge i_mclk);
    // Pick which select releases first
    if (second_first) begin
      o_cs_second_n <= 1'b1;
    end else begin
      o_cs_first_n <= 1'b1;
    end
    @(negedge i_mclk);
    o_cs_first_n <= 1'b1;
    o_cs_second_n <= 1'b1;
    o_select <= {2'h0, ~addr};
    o_nibble <= ~val;
  endtask
endmodule

// File: sdd_display_driver_test.sv
// Self-checking bench for the segment display driver
`timescale 1ns/1ns
module sdd_display_driver_test;
  import sdd_pkg::*;
  localparam int OSC = 4; // Short oscillator tick
  logic i_mclk, i_reset_n, i_proc_mode, i_code_b, i_timebase_pin, i_common_plane;
  logic cs1_n, cs2_n; // Chip selects from the source
  logic [3:0] nib, sel; // Data and selects from the source
  logic o_common_plane, o_common_plane_oe;
  logic [27:0] o_segments;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0; // Cycle counter for timeout
  sdd_seg_t hex_tab [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
    7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
  sdd_seg_t cb_tab [6] = '{7'h40, 7'h79, 7'h76, 7'h38, 7'h73, 7'h00};

  sdd_source_model src (.i_mclk(i_mclk), .o_nibble(nib), .o_select(sel),
    .o_cs_first_n(cs1_n), .o_cs_second_n(cs2_n));

  sdd_display_driver #(.OSC_CYCLES(OSC)) dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_proc_mode(i_proc_mode), .i_code_b(i_code_b), .i_nibble_bit_ones(nib[0]),
    .i_nibble_bit_twos(nib[1]), .i_nibble_bit_fours(nib[2]), .i_nibble_bit_eights(nib[3]),
    .i_digit_one_select(sel[0]), .i_digit_two_select(sel[1]),
    .i_digit_three_select(sel[2]), .i_digit_four_select(sel[3]),
    .i_chip_sel_first_n(cs1_n), .i_chip_sel_second_n(cs2_n),
    .i_timebase_pin(i_timebase_pin), .i_common_plane(i_common_plane),
    .o_common_plane(o_common_plane), .o_common_plane_oe(o_common_plane_oe),
    .o_segments(o_segments));

  // ============================================================
  // Clock, timeout, verdict
  // ============================================================
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ============================================================
  // Helpers
  // ============================================================
  task automatic check(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  function automatic sdd_seg_t exp_pat(input logic [3:0] v, input logic cb);
    return (cb && v > 4'h9) ? cb_tab[v - 4'ha] : hex_tab[v];
  endfunction
  task automatic chk_seg(input int d, input logic [3:0] v, input logic p);
    check(o_segments[7*d +: 7] === (exp_pat(v, i_code_b) ^ {7{p}}), "digit pattern");
  endtask
  task automatic wait_bp_rise();
    int n;
    n = 0;
    @(negedge i_mclk);
    while (o_common_plane !== 1'b0 && n < 1000) begin
      @(negedge i_mclk);
      n++;
    end
    while (o_common_plane !== 1'b1 && n < 1000) begin
      @(negedge i_mclk);
      n++;
    end
  endtask

  // ============================================================
  // Scenarios
  // ============================================================
  task automatic t_backplane();
    int t0;
    src.mux_write(2'h0, 4'h8);
    wait_bp_rise();
    t0 = cyc;
    wait_bp_rise();
    check((cyc - t0) == 128 * OSC, "backplane period");
    repeat (10) @(negedge i_mclk);
    check(o_segments[6:0] === {7{~o_common_plane}}, "lit phase");
    check(o_common_plane_oe === 1'b1, "driver on");
    $display("test backplane done");
  endtask
  task automatic t_slave();
    i_timebase_pin = 1'b0;
    repeat (50) @(negedge i_mclk);
    check(o_common_plane_oe === 1'b1, "short low ignored");
    i_timebase_pin = 1'b1;
    @(negedge i_mclk);
    i_timebase_pin = 1'b0;
    repeat (110) @(negedge i_mclk);
    check(o_common_plane_oe === 1'b0, "driver off");
    for (int p = 0; p < 2; p++) begin
      i_common_plane = p[0];
      repeat (2) @(negedge i_mclk);
      chk_seg(0, 4'h8, p[0]);
    end
    $display("test slave done");
  endtask
  task automatic t_mux(input logic cb);
    i_code_b = cb;
    for (int v = 0; v < 16; v++) begin
      i_common_plane = v[0];
      src.mux_write(v[1:0], v[3:0]);
      repeat (2) @(negedge i_mclk);
      chk_seg(v % 4, v[3:0], v[0]);
    end
    $display("test mux done");
  endtask
  task automatic t_proc();
    i_proc_mode = 1'b1;
    i_code_b = 1'b0;
    for (int a = 0; a < 4; a++) begin
      src.proc_write(a[1:0], 4'(a + 10), a[0]);
      repeat (2) @(negedge i_mclk);
      chk_seg(3 - a, 4'(a + 10), i_common_plane);
    end
    i_code_b = 1'b1;
    src.proc_write(2'h3, 4'hf, 1'b1);
    i_code_b = 1'b0;
    repeat (2) @(negedge i_mclk);
    check(o_segments[6:0] === {7{i_common_plane}}, "blank digit");
    for (int a = 0; a < 3; a++) begin
      chk_seg(3 - a, 4'(a + 10), i_common_plane);
    end
    i_timebase_pin = 1'b1;
    repeat (2) @(negedge i_mclk);
    check(o_common_plane_oe === 1'b1, "driver back on");
    $display("test proc done");
  endtask

  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    i_reset_n = 1'b0;
    i_proc_mode = 1'b0;
    i_code_b = 1'b0;
    i_timebase_pin = 1'b1;
    i_common_plane = 1'b0;
    repeat (8) @(negedge i_mclk);
    check(o_segments === 28'h0000000, "reset segments");
    i_reset_n = 1'b1;
    @(negedge i_mclk);
    check(o_common_plane_oe === 1'b1, "reset driver");
    $display("test reset done");
    t_backplane();
    t_slave();
    t_mux(1'b0);
    t_mux(1'b1);
    t_proc();
    print_verdict();
  end
endmodule
